// File: rtl/eirq_flags.sv
// External request flag register with AXI4-Lite access
// Function
// - One nonmaskable input plus eight independent maskable request inputs.
// - Sixteen-bit flag register; bits 7..0 are flags, 15..8 read zero.
// - Level sensing: flag is one while pin low, zero while pin high.
// - Edge sensing: selected edge sets the flag, which then holds.
// - Software clears an edge flag only by writing zero after reading it as one.
// - Edge flag also clears when exception handling for that pin runs.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
module eirq_flags (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Request pins
  input  wire logic                          nmi_request_in,
  input  wire logic [eirq_pkg::EIRQ_PINS-1:0] maskable_request_pins,
  // Exception handling acknowledge, one pulse per handled pin
  input  wire logic [eirq_pkg::EIRQ_PINS-1:0] exception_ack,
  // Request outputs to the processor
  output logic [eirq_pkg::EIRQ_PINS-1:0]     pin_request_out,
  output logic                               nmi_request_out,
  output logic                               irq,
  // AXI4-Lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [eirq_pkg::EIRQ_AW-1:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [eirq_pkg::EIRQ_AW-1:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp
);
  import eirq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [EIRQ_PINS-1:0]   flag_q, flag_d;
  logic [EIRQ_PINS-1:0]   armed_q, armed_d;
  logic [2*EIRQ_PINS-1:0] sense_q;
  logic [EV_W-1:0]        stat_q, stat_d;
  logic [EV_W-1:0]        mask_q;
  logic                   nmi_m_q, nmi_s_q, nmi_p_q;
  logic [EIRQ_AW-1:0]     awaddr_q, araddr_q;
  logic                   aw_full_q, w_full_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   bvalid_q, rvalid_q;
  logic [1:0]             bresp_q, rresp_q;
  logic [31:0]            rdata_q;
  eirq_detect_t           det;

  eirq_sync_detect u_detect (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pins_in   (maskable_request_pins),
    .sense_sel (sense_q),
    .detect    (det)
  );

  function automatic logic known_addr(input logic [EIRQ_AW-1:0] a);
    return a == OFF_FLAGS || a == OFF_SENSE || a == OFF_STATUS ||
           a == OFF_MASK || a == OFF_PENDING;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire do_write = aw_full_q && w_full_q && !bvalid_q;
  wire do_read  = s_axi_arvalid && !rvalid_q;
  wire [EIRQ_AW-1:0] ra = s_axi_araddr;
  wire wr_flags = do_write && awaddr_q == OFF_FLAGS && wstrb_q[0];
  wire wr_sense = do_write && awaddr_q == OFF_SENSE;
  wire wr_stat  = do_write && awaddr_q == OFF_STATUS && wstrb_q[0];
  wire wr_mask  = do_write && awaddr_q == OFF_MASK && wstrb_q[0];
  wire rd_flags = do_read && ra == OFF_FLAGS;
  wire [EIRQ_PINS-1:0] edge_mode;
  wire [31:0] rd_mux;

  genvar g;
  generate
    for (g = 0; g < EIRQ_PINS; g++) begin : g_mode
      assign edge_mode[g] = eirq_sense_t'(sense_q[2*g +: 2]) != SENSE_LOW;
    end
  endgenerate

  assign rd_mux =
      (ra == OFF_FLAGS)   ? {16'h0000, BYTE_ZERO, flag_q} :
      (ra == OFF_SENSE)   ? {16'h0000, sense_q} :
      (ra == OFF_STATUS)  ? {29'h0000_0000, stat_q} :
      (ra == OFF_MASK)    ? {29'h0000_0000, mask_q} :
      (ra == OFF_PENDING) ? {24'h00_0000, flag_q}
                          : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Flag next state
  wire [EIRQ_PINS-1:0] wr_zero = wr_flags ? ~wdata_q[EIRQ_PINS-1:0] : '0;
  wire [EIRQ_PINS-1:0] sw_clr  = wr_zero & armed_q;
  wire [EIRQ_PINS-1:0] edge_clr = (sw_clr | exception_ack) & edge_mode;
  wire [EIRQ_PINS-1:0] edge_nxt = det.edge_ev | (flag_q & ~edge_clr);
  wire [EIRQ_PINS-1:0] new_set  = edge_mode & det.edge_ev & ~flag_q;

  always_comb begin
    flag_d  = (edge_mode & edge_nxt) | (~edge_mode & det.level);
    // Read of a one arms the clear; any write to the flags then consumes it, and a zero bit clears
    armed_d = (armed_q & ~(wr_flags ? {EIRQ_PINS{1'b1}} : '0) & flag_q)
              | (rd_flags ? flag_q & edge_mode : '0);
    stat_d  = stat_q & ~(wr_stat ? wdata_q[EV_W-1:0] : '0);
    stat_d[EV_FLAG_SET] = stat_d[EV_FLAG_SET] | (|new_set);
    stat_d[EV_NMI]      = stat_d[EV_NMI] | (nmi_s_q & ~nmi_p_q);
    stat_d[EV_BAD_ADDR] = stat_d[EV_BAD_ADDR]
                          | (do_read && !known_addr(ra))
                          | (do_write && !known_addr(awaddr_q));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q  <= FLAGS_RST[EIRQ_PINS-1:0];
      armed_q <= '0;
      sense_q <= SENSE_RST;
      stat_q  <= '0;
      mask_q  <= '0;
      nmi_m_q <= 1'b0;
      nmi_s_q <= 1'b0;
      nmi_p_q <= 1'b0;
    end else begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
      stat_q  <= stat_d;
      nmi_m_q <= nmi_request_in;
      nmi_s_q <= nmi_m_q;
      nmi_p_q <= nmi_s_q;
      if (wr_sense && wstrb_q[0]) sense_q[7:0]  <= wdata_q[7:0];
      if (wr_sense && wstrb_q[1]) sense_q[15:8] <= wdata_q[15:8];
      if (wr_mask) mask_q <= wdata_q[EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= known_addr(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_read) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= known_addr(ra) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Pin and NMI outputs straight from flops; irq is stat_q gated by mask_q
  assign pin_request_out = flag_q;
  assign nmi_request_out = nmi_s_q;
  assign irq             = |(stat_q & mask_q);

endmodule

// File: inc/eirq_pkg.sv
// Package: register map, field layout and types of the external request flag block
package eirq_pkg;

  localparam int          EIRQ_PINS       = 8;
  localparam int          EIRQ_AW         = 5;
  localparam int          EIRQ_FLAG_W     = 16;

  // Byte offsets of the register words
  localparam logic [4:0]  OFF_FLAGS       = 5'h00;
  localparam logic [4:0]  OFF_SENSE       = 5'h04;
  localparam logic [4:0]  OFF_STATUS      = 5'h08;
  localparam logic [4:0]  OFF_MASK        = 5'h0C;
  localparam logic [4:0]  OFF_PENDING     = 5'h10;

  // Reset values, zero byte and bus response codes
  localparam logic [15:0] FLAGS_RST       = 16'h0000;
  localparam logic [15:0] SENSE_RST       = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // Two sense-select bits per pin
  typedef enum logic [1:0] {
    SENSE_LOW     = 2'b00,
    SENSE_FALL    = 2'b01,
    SENSE_RISE    = 2'b10,
    SENSE_BOTH    = 2'b11
  } eirq_sense_t;

  // Status event bits
  localparam int          EV_FLAG_SET     = 0;
  localparam int          EV_NMI          = 1;
  localparam int          EV_BAD_ADDR     = 2;
  localparam int          EV_W            = 3;

  typedef struct packed {
    logic [EIRQ_PINS-1:0] level;
    logic [EIRQ_PINS-1:0] edge_ev;
  } eirq_detect_t;

endpackage

// File: rtl/eirq_sync_detect.sv
// Synchroniser and edge detector for the external request pins
module eirq_sync_detect
  import eirq_pkg::*;
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Raw pins and sense selection
  input  wire logic [EIRQ_PINS-1:0]    pins_in,
  input  wire logic [2*EIRQ_PINS-1:0]  sense_sel,
  // Detected requests
  output eirq_pkg::eirq_detect_t       detect
);

  logic [EIRQ_PINS-1:0] meta_q;
  logic [EIRQ_PINS-1:0] sync_q;
  logic [EIRQ_PINS-1:0] prev_q;
  logic [EIRQ_PINS-1:0] fall_w;
  logic [EIRQ_PINS-1:0] rise_w;

  // Idle high so no false edge leaves reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign fall_w = prev_q & ~sync_q;
  assign rise_w = ~prev_q & sync_q;

  always_comb begin
    detect.level   = ~sync_q;
    detect.edge_ev = '0;
    for (int i = 0; i < EIRQ_PINS; i++) begin
      unique case (eirq_sense_t'(sense_sel[2*i +: 2]))
        SENSE_FALL: detect.edge_ev[i] = fall_w[i];
        SENSE_RISE: detect.edge_ev[i] = rise_w[i];
        SENSE_BOTH: detect.edge_ev[i] = fall_w[i] | rise_w[i];
        SENSE_LOW:  detect.edge_ev[i] = 1'b0;
      endcase
    end
  end

endmodule

// File: testbench/eirq_flags_chk.sv
// Assertion checker for the external request flag block
module eirq_flags_chk
  import eirq_pkg::*;
(
  // Clock, reset and pins
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 nmi_request_in,
  input wire logic                 nmi_request_out,
  input wire logic [EIRQ_PINS-1:0] maskable_request_pins,
  input wire logic [EIRQ_PINS-1:0] exception_ack,
  input wire logic [EIRQ_PINS-1:0] pin_request_out,
  // Register bus
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [EIRQ_AW-1:0]   s_axi_araddr,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [EIRQ_AW-1:0] ra_q;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  // Both halves taken while no response is pending
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid; endsequence
  ////////////////////////////////////////////////////////////////////////
  property p_nmi; nmi_request_in [*4] |-> nmi_request_out; endproperty
  property p_rsvd; s_axi_rvalid && ra_q == OFF_FLAGS |-> s_axi_rdata[15:8] == BYTE_ZERO;
  endproperty
  // Flags fall only by write, acknowledge or a high pin
  property p_hold; !s_axi_bvalid |-> (($past(pin_request_out) & ~pin_request_out
    & ~$past(exception_ack) & ~$past(maskable_request_pins, 3)) == 8'h00); endproperty
  // No flag rises while the pin stood high and still
  property p_set; ((pin_request_out & ~$past(pin_request_out) & $past(maskable_request_pins, 3)
    & $past(maskable_request_pins, 4)) == 8'h00); endproperty
  property p_rans; s_rd |=> s_axi_rvalid; endproperty
  // Halves land one edge, the write commits the next, bvalid is seen after that
  property p_bans; s_wr |-> ##2 s_axi_bvalid; endproperty
  property p_rstay; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_bstay; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi output lags");
  a_rsvd: assert property (p_rsvd) else $error("upper flag byte set");
  a_hold: assert property (p_hold) else $error("flag lost");
  a_set: assert property (p_set) else $error("flag without cause");
  a_rans: assert property (p_rans) else $error("read answer late");
  a_bans: assert property (p_bans) else $error("write answer late");
  a_rstay: assert property (p_rstay) else $error("read data dropped");
  a_bstay: assert property (p_bstay) else $error("write response dropped");
endmodule
bind eirq_flags eirq_flags_chk chk_i (.*);

// File: testbench/eirq_pin_drv.sv
// Board-side driver of the request pins
module eirq_pin_drv (
  // Clock and wanted levels
  input  wire logic       aclk,
  input  wire logic [7:0] want_pins,
  input  wire logic       want_nmi,
  // Pins
  output logic      [7:0] pins,
  output logic            nmi
);
  timeunit 1ns;
  timeprecision 1ps;
  // Changes just after an edge, never mid-cycle
  always_ff @(posedge aclk) begin
    pins <= want_pins;
    nmi  <= want_nmi;
  end
endmodule

// File: testbench/tb_top.sv
// Testbench for the external request flag block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eirq_pkg::*;
  logic        aclk, aresetn, nmi_request_in, nmi_request_out, irq, want_nmi;
  logic [7:0]  maskable_request_pins, exception_ack, pin_request_out, want_pins;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, sns;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_fail, samples_checked;
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  eirq_flags dut (.*);
  eirq_pin_drv drv (.aclk(aclk), .want_pins(want_pins), .want_nmi(want_nmi),
                    .pins(maskable_request_pins), .nmi(nmi_request_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // A wait that runs out ends the run
  task automatic tmo(int n);
    if (n >= 50) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    int n;
    bit ad = 1'b0;
    bit wd = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    for (n = 0; n < 50 && !(ad && wd); n++) begin
      @(posedge aclk);
      ad |= s_axi_awready;
      wd |= s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    tmo(n);
    // Late bready so a held response is seen too
    for (n = 0; n < 50 && !s_axi_bvalid; n++) @(posedge aclk);
    tmo(n);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
  endtask
  task automatic rd(logic [4:0] a, logic [1:0] er = RESP_OKAY);
    int n;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) break;
    end
    tmo(n);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 50 && !s_axi_rvalid; n++) @(posedge aclk);
    tmo(n);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    rd(OFF_FLAGS);
    chk("flags rst", 32'h0000_0000, rdat);
    rd(OFF_SENSE);
    chk("sense rst", 32'h0000_0000, rdat);
    wr(OFF_FLAGS, 32'hFFFF_FFFF);
    rd(OFF_FLAGS);
    chk("flags ro", 32'h0000_0000, rdat);
  endtask
  task automatic s_level();
    want_pins <= 8'hFE;
    cyc(6);
    rd(OFF_FLAGS);
    chk("lvl low", 32'h0000_0001, rdat);
    want_pins <= 8'hFF;
    cyc(6);
    chk("lvl high", 32'h0000_0000, 32'(pin_request_out));
  endtask
  task automatic s_edge();
    sns = 32'h0000_0004;
    wr(OFF_SENSE, sns);
    want_pins <= 8'hFD;
    cyc(6);
    want_pins <= 8'hFF;
    cyc(6);
    chk("edge held", 32'h0000_0002, 32'(pin_request_out));
    // Mirror read must not arm the clear
    rd(OFF_PENDING);
    chk("pending", 32'h0000_0002, rdat);
    wr(OFF_FLAGS, 32'h0000_0000);
    chk("no read", 32'h0000_0002, 32'(pin_request_out));
    rd(OFF_FLAGS);
    wr(OFF_FLAGS, 32'h0000_0002);
    wr(OFF_FLAGS, 32'h0000_0000);
    chk("one then zero", 32'h0000_0002, 32'(pin_request_out));
    rd(OFF_FLAGS);
    chk("edge rd", 32'h0000_0002, rdat);
    wr(OFF_FLAGS, 32'h0000_0000);
    chk("rd clr", 32'h0000_0000, 32'(pin_request_out));
  endtask
  task automatic s_modes();
    for (int m = 1; m < 4; m++) begin
      sns |= 32'(m) << (2 * (m + 3));
      wr(OFF_SENSE, sns);
      want_pins <= ~(8'h01 << (m + 3));
      cyc(6);
      want_pins <= 8'hFF;
      cyc(6);
      chk("mode set", 32'(1) << (m + 3), 32'(pin_request_out));
      exception_ack <= 8'h01 << (m + 3);
      cyc(1);
      exception_ack <= 8'h00;
      cyc(3);
      chk("ack clr", 32'h0000_0000, 32'(pin_request_out));
    end
  endtask
  task automatic s_irq();
    wr(OFF_STATUS, 32'h0000_0007);
    wr(OFF_MASK, 32'h0000_0007);
    want_nmi <= 1'b1;
    cyc(6);
    chk("nmi out", 32'h0000_0001, 32'(nmi_request_out));
    rd(OFF_STATUS);
    chk("status", 32'h0000_0002, rdat);
    chk("irq on", 32'h0000_0001, 32'(irq));
    wr(OFF_STATUS, 32'h0000_0002);
    chk("irq clr", 32'h0000_0000, 32'(irq));
    rd(5'h14, RESP_SLVERR);
    chk("unmapped", 32'h0000_0000, rdat);
    chk("irq bad", 32'h0000_0001, 32'(irq));
    wr(OFF_MASK, 32'h0000_0000);
    chk("irq mask", 32'h0000_0000, 32'(irq));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    want_pins = 8'hFF;
    want_nmi = 1'b0;
    exception_ack = 8'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    s_level();
    s_edge();
    s_modes();
    s_irq();
    summarize();
  end
endmodule
